// >>> hw/gsc_map.vh
// Command codes, field positions, subcommands and mode codes of the gauge map
`ifndef GSC_MAP_VH
`define GSC_MAP_VH

// Bus target address, arbitrary neutral value
`define GSC_DEV_ADDR        7'h55

// Even command code of each standard word, then the last (odd) code of the standard set
`define GSC_CMD_CONTROL     8'h00
`define GSC_CMD_CELL_TEMP   8'h02
`define GSC_CMD_VOLTAGE     8'h04
`define GSC_CMD_FLAGS       8'h06
`define GSC_CMD_NOM_CAP     8'h08
`define GSC_CMD_FULL_AVAIL  8'h0A
`define GSC_CMD_REMAIN_CAP  8'h0C
`define GSC_CMD_FULL_CHG    8'h0E
`define GSC_CMD_AVG_CURR    8'h10
`define GSC_CMD_STBY_CURR   8'h12
`define GSC_CMD_MAX_LOAD    8'h14
`define GSC_CMD_AVAIL_NRG   8'h16
`define GSC_CMD_AVG_PWR     8'h18
`define GSC_CMD_GAP         8'h1A
`define GSC_CMD_CHG_PCT     8'h1C
`define GSC_CMD_INT_TEMP    8'h1E
`define GSC_CMD_HEALTH_PCT  8'h20
`define GSC_CMD_LAST        8'h21

// Number of word slots from code 0x00 to 0x21
`define GSC_WORD_COUNT      17
`define GSC_WORD_RESET      16'h0000

// Control subcommands
`define GSC_SUB_STATUS      16'h0000
`define GSC_SUB_DEV_TYPE    16'h0001
`define GSC_SUB_FW_VER      16'h0002
`define GSC_SUB_HW_VER      16'h0003
`define GSC_SUB_PREV_CMD    16'h0007
`define GSC_SUB_SET_DEEP    16'h0010
`define GSC_SUB_SET_HIB     16'h0011
`define GSC_SUB_CLR_HIB     16'h0012
`define GSC_SUB_RESTORE     16'h0015
`define GSC_SUB_LOCK        16'h0020
`define GSC_SUB_RESET       16'h0041
`define GSC_PREV_LIMIT      16'h0015

// Status word bit positions
`define GSC_ST_HIBE         15
`define GSC_ST_LOCKED       13
`define GSC_ST_INITCOMP     7
`define GSC_ST_HIB_REQ      6
`define GSC_ST_DEEP         5
`define GSC_ST_SLEEP        4

// Power modes
`define GSC_MODE_INIT       3'h0
`define GSC_MODE_NORMAL     3'h1
`define GSC_MODE_SLEEP      3'h2
`define GSC_MODE_DEEP       3'h3
`define GSC_MODE_HIB        3'h4

`endif

// >>> hw/gsc_i2c_target.v
// Two-wire bus target: byte framing, address match, acknowledge
`timescale 1ns/10ps
`include "gsc_map.vh"

module gsc_i2c_target #(
    parameter [6:0] DEV_ADDR = `GSC_DEV_ADDR
) (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Address acknowledge allowed
    input  wire       enable,
    // Bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_oe,
    // Byte side
    output reg        start_stb,
    output reg        wr_stb,
    output reg        wr_first,
    output reg  [7:0] wr_data,
    output reg        rd_stb,
    input  wire [7:0] rd_data
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ADDR  = 2'h1;
    localparam [1:0] ST_WRITE = 2'h2;
    localparam [1:0] ST_READ  = 2'h3;

    reg  [1:0] state_reg;
    reg  [3:0] bit_reg;
    reg  [7:0] shift_reg;
    reg        scl_d_reg;
    reg        sda_d_reg;
    reg        oe_reg;
    reg        rw_reg;
    reg        first_reg;

    wire scl_rise = scl_in & ~scl_d_reg;
    wire scl_fall = ~scl_in & scl_d_reg;
    wire start_c  = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
    wire stop_c   = scl_in & scl_d_reg & ~sda_d_reg & sda_in;

    // Open drain: enable pulls the line low
    assign sda_oe = oe_reg;

    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            bit_reg   <= 4'h0;
            shift_reg <= 8'h00;
            scl_d_reg <= 1'h1;
            sda_d_reg <= 1'h1;
            oe_reg    <= 1'h0;
            rw_reg    <= 1'h0;
            first_reg <= 1'h0;
            start_stb <= 1'h0;
            wr_stb    <= 1'h0;
            wr_first  <= 1'h0;
            wr_data   <= 8'h00;
            rd_stb    <= 1'h0;
        end else begin
            scl_d_reg <= scl_in;
            sda_d_reg <= sda_in;
            start_stb <= 1'h0;
            wr_stb    <= 1'h0;
            rd_stb    <= 1'h0;
            if (start_c) begin
                state_reg <= ST_ADDR;
                bit_reg   <= 4'h0;
                oe_reg    <= 1'h0;
                start_stb <= 1'h1;
            end else if (stop_c) begin
                state_reg <= ST_IDLE;
                oe_reg    <= 1'h0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise && bit_reg < 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_in};
                            bit_reg   <= bit_reg + 4'h1;
                        end else if (scl_fall && bit_reg == 4'h8) begin
                            if (state_reg == ST_WRITE) begin
                                oe_reg    <= 1'h1;
                                bit_reg   <= 4'h9;
                                wr_stb    <= 1'h1;
                                wr_data   <= shift_reg;
                                wr_first  <= first_reg;
                                first_reg <= 1'h0;
                            end else if (enable &&
                                         shift_reg[7:1] == DEV_ADDR) begin
                                oe_reg    <= 1'h1;
                                bit_reg   <= 4'h9;
                                rw_reg    <= shift_reg[0];
                                first_reg <= 1'h1;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else if (scl_fall && bit_reg == 4'h9) begin
                            bit_reg <= 4'h0;
                            if (state_reg == ST_ADDR && rw_reg) begin
                                state_reg <= ST_READ;
                                shift_reg <= rd_data;
                                oe_reg    <= ~rd_data[7];
                                rd_stb    <= 1'h1;
                            end else begin
                                state_reg <= ST_WRITE;
                                oe_reg    <= 1'h0;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall && bit_reg < 4'h7) begin
                            shift_reg <= {shift_reg[6:0], 1'h0};
                            oe_reg    <= ~shift_reg[6];
                            bit_reg   <= bit_reg + 4'h1;
                        end else if (scl_fall && bit_reg == 4'h7) begin
                            oe_reg  <= 1'h0;
                            bit_reg <= 4'h8;
                        end else if (scl_rise && bit_reg == 4'h8) begin
                            // Controller not-acknowledge ends the read
                            if (sda_in)
                                state_reg <= ST_IDLE;
                            else
                                bit_reg <= 4'h9;
                        end else if (scl_fall && bit_reg == 4'h9) begin
                            shift_reg <= rd_data;
                            oe_reg    <= ~rd_data[7];
                            bit_reg   <= 4'h0;
                            rd_stb    <= 1'h1;
                        end
                    end
                    default: begin
                        oe_reg <= 1'h0;
                    end
                endcase
            end
        end
    end
endmodule

// >>> hw/gsc_command_map.v
// Standard command map of the gauge behind its two-wire bus
`timescale 1ns/10ps
`include "gsc_map.vh"

module gsc_command_map #(
    parameter [6:0]  DEV_ADDR      = `GSC_DEV_ADDR,
    // Identity values below are arbitrary
    parameter [15:0] DEVICE_TYPE   = 16'h1234,
    parameter [15:0] FW_VERSION    = 16'h0100,
    parameter [15:0] HW_VERSION    = 16'h00A0,
    parameter        LOCK_AT_RESET = 1'h0
) (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Two-wire bus
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    // Updates from the gauging engine
    input  wire        upd_stb,
    input  wire [7:0]  upd_code,
    input  wire [15:0] upd_data,
    // Power mode events
    input  wire        init_done,
    input  wire        sleep_cond,
    input  wire        wake_evt,
    output reg  [2:0]  power_mode,
    output reg         locked_state,
    // Control requests
    output reg         reset_req,
    output reg         restore_req,
    // Extended command port
    output reg         ext_wr_stb,
    output reg  [7:0]  ext_code,
    output reg  [7:0]  ext_data,
    input  wire [7:0]  ext_rd_data
);
    localparam [2:0] RESP_STATUS = 3'h0;
    localparam [2:0] RESP_DTYPE  = 3'h1;
    localparam [2:0] RESP_FW     = 3'h2;
    localparam [2:0] RESP_HW     = 3'h3;
    localparam [2:0] RESP_PREV   = 3'h4;

    wire        start_stb;
    wire        wr_stb;
    wire        wr_first;
    wire [7:0]  wr_data;
    wire        rd_stb;
    wire [7:0]  rd_byte;
    wire        bus_enable;

    reg  [7:0]  ptr_reg;
    reg  [7:0]  ctrl_lsb_reg;
    reg  [2:0]  resp_sel_reg;
    reg  [15:0] prev_sub_reg;
    reg         deep_flag_reg;
    reg         hib_req_reg;
    reg         hibe_reg;
    reg  [15:0] word_reg [0:`GSC_WORD_COUNT-1];

    wire [6:0]  ptr_idx  = ptr_reg[7:1];
    wire        in_std   = (ptr_reg <= `GSC_CMD_LAST);
    // gap pair and codes past the set never stored
    wire        mapped   = in_std && (ptr_idx != `GSC_CMD_GAP >> 1);
    wire        host_wr  = wr_stb && !wr_first;
    wire [15:0] subcmd   = {wr_data, ctrl_lsb_reg};
    wire [6:0]  upd_idx  = upd_code[7:1];
    wire [15:0] status_word;
    reg  [15:0] ctrl_word;
    reg  [15:0] sel_word;
    reg         writable;

    // Open drain: the line is only ever pulled low
    assign sda_out = 1'h0;

    // bus answered only in operating modes
    assign bus_enable = (power_mode == `GSC_MODE_NORMAL) ||
                        (power_mode == `GSC_MODE_SLEEP) ||
                        (power_mode == `GSC_MODE_DEEP);

    gsc_i2c_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_target (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .enable    (bus_enable),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .sda_oe    (sda_oe),
        .start_stb (start_stb),
        .wr_stb    (wr_stb),
        .wr_first  (wr_first),
        .wr_data   (wr_data),
        .rd_stb    (rd_stb),
        .rd_data   (rd_byte)
    );

    assign status_word = {hibe_reg, 1'h0, locked_state, 5'h00,
                          power_mode != `GSC_MODE_INIT, hib_req_reg,
                          deep_flag_reg,
                          (power_mode == `GSC_MODE_SLEEP) ||
                          (power_mode == `GSC_MODE_DEEP), 4'h0};

    // Control word answer chosen by the last subcommand
    always @* begin
        case (resp_sel_reg)
            RESP_DTYPE: ctrl_word = DEVICE_TYPE;
            RESP_FW:    ctrl_word = FW_VERSION;
            RESP_HW:    ctrl_word = HW_VERSION;
            RESP_PREV:  ctrl_word = prev_sub_reg;
            default:    ctrl_word = status_word;
        endcase
    end

    // word selected by the command pointer
    always @* begin
        if (ptr_idx == 7'h00)
            sel_word = ctrl_word;
        else if (mapped)
            sel_word = word_reg[ptr_idx[4:0]];
        else
            sel_word = `GSC_WORD_RESET;
    end

    // even code low byte, odd code high byte
    // codes above the standard set read from the extended port
    assign rd_byte = !in_std ? ext_rd_data :
                     ptr_reg[0] ? sel_word[15:8] : sel_word[7:0];

    // locked state narrows host write rights
    always @* begin
        writable = mapped;
        if (locked_state &&
            ptr_idx != (`GSC_CMD_CONTROL >> 1) &&
            ptr_idx != (`GSC_CMD_CELL_TEMP >> 1))
            writable = 1'h0;
    end

    // pointer from the command byte, then advances per byte
    always @(posedge clk) begin
        if (sys_rst)
            ptr_reg <= 8'h00;
        else if (wr_stb && wr_first)
            ptr_reg <= wr_data;
        else if (host_wr || rd_stb)
            ptr_reg <= ptr_reg + 8'h01;
    end

    // Word storage; slot 0 holds nothing, the control word is computed
    genvar gi;
    generate
        for (gi = 1; gi < `GSC_WORD_COUNT; gi = gi + 1) begin : g_word
            always @(posedge clk) begin
                if (sys_rst) begin
                    word_reg[gi] <= `GSC_WORD_RESET;
                end else if (host_wr && writable && ptr_idx == gi) begin
                    // byte lane from the low code bit
                    if (ptr_reg[0])
                        word_reg[gi][15:8] <= wr_data;
                    else
                        word_reg[gi][7:0] <= wr_data;
                end else if (upd_stb && upd_idx == gi &&
                             upd_code <= `GSC_CMD_LAST &&
                             upd_idx != (`GSC_CMD_GAP >> 1)) begin
                    // Engine keeps the values; a host write takes priority
                    word_reg[gi] <= upd_data;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        word_reg[0] <= `GSC_WORD_RESET;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            ext_wr_stb <= 1'h0;
            ext_code   <= 8'h00;
            ext_data   <= 8'h00;
        end else begin
            ext_wr_stb <= host_wr && !in_std;
            if (host_wr && !in_std) begin
                ext_code <= ptr_reg;
                ext_data <= wr_data;
            end
        end
    end

    // subcommand executed when its high byte lands
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_lsb_reg <= 8'h00;
            resp_sel_reg <= RESP_STATUS;
            prev_sub_reg <= 16'h0000;
            locked_state <= LOCK_AT_RESET;
            reset_req    <= 1'h0;
            restore_req  <= 1'h0;
        end else begin
            reset_req   <= 1'h0;
            restore_req <= 1'h0;
            if (host_wr && ptr_reg == `GSC_CMD_CONTROL)
                ctrl_lsb_reg <= wr_data;
            if (host_wr && ptr_reg == (`GSC_CMD_CONTROL + 8'h01)) begin
                if (subcmd < `GSC_PREV_LIMIT)
                    prev_sub_reg <= subcmd;
                resp_sel_reg <= RESP_STATUS;
                case (subcmd)
                    `GSC_SUB_DEV_TYPE: resp_sel_reg <= RESP_DTYPE;
                    `GSC_SUB_FW_VER:   resp_sel_reg <= RESP_FW;
                    `GSC_SUB_HW_VER:   resp_sel_reg <= RESP_HW;
                    `GSC_SUB_PREV_CMD: begin
                        if (!locked_state)
                            resp_sel_reg <= RESP_PREV;
                    end
                    // one-way move into the locked state
                    `GSC_SUB_LOCK:     locked_state <= 1'h1;
                    `GSC_SUB_RESTORE:  restore_req <= !locked_state;
                    `GSC_SUB_RESET:    reset_req <= !locked_state;
                    default:           resp_sel_reg <= RESP_STATUS;
                endcase
            end
        end
    end

    wire sub_hit = host_wr && ptr_reg == (`GSC_CMD_CONTROL + 8'h01);

    // power modes: automatic moves plus host requests
    always @(posedge clk) begin
        if (sys_rst) begin
            power_mode    <= `GSC_MODE_INIT;
            deep_flag_reg <= 1'h0;
            hib_req_reg   <= 1'h0;
            hibe_reg      <= 1'h0;
        end else begin
            // Clear first so a same-cycle hibernate entry still flags
            if (sub_hit && subcmd == `GSC_SUB_CLR_HIB) begin
                hib_req_reg <= 1'h0;
                hibe_reg    <= 1'h0;
            end
            case (power_mode)
                `GSC_MODE_INIT: begin
                    if (init_done)
                        power_mode <= `GSC_MODE_NORMAL;
                end
                `GSC_MODE_NORMAL: begin
                    if (sleep_cond)
                        power_mode <= `GSC_MODE_SLEEP;
                end
                `GSC_MODE_SLEEP: begin
                    if (!sleep_cond)
                        power_mode <= `GSC_MODE_NORMAL;
                    else if (hib_req_reg) begin
                        power_mode <= `GSC_MODE_HIB;
                        hibe_reg   <= 1'h1;
                    end else if (deep_flag_reg)
                        power_mode <= `GSC_MODE_DEEP;
                end
                `GSC_MODE_DEEP: begin
                    // Any traffic drops back and clears the request
                    if (start_stb) begin
                        power_mode    <= `GSC_MODE_SLEEP;
                        deep_flag_reg <= 1'h0;
                    end else if (!sleep_cond) begin
                        power_mode    <= `GSC_MODE_NORMAL;
                        deep_flag_reg <= 1'h0;
                    end
                end
                `GSC_MODE_HIB: begin
                    // Request bit clears on the way out
                    if (wake_evt) begin
                        power_mode  <= `GSC_MODE_NORMAL;
                        hib_req_reg <= 1'h0;
                    end
                end
                default: power_mode <= `GSC_MODE_INIT;
            endcase
            // Requests come last so a set beats a same-cycle clear
            if (sub_hit && subcmd == `GSC_SUB_SET_DEEP)
                deep_flag_reg <= 1'h1;
            if (sub_hit && subcmd == `GSC_SUB_SET_HIB)
                hib_req_reg <= 1'h1;
        end
    end
endmodule

// >>> testbench/gsc_host_model.sv
// Host-side two-wire bus controller model
`timescale 1ns/10ps
`include "gsc_map.vh"
module gsc_host_model (
    // Clock
    input  wire logic clk,
    // Bus: SCL driven, SDA released or pulled low
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // SDA only moves while SCL is low, so no false start or stop
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        hold(3);
        scl = 1'b1;
        hold(3);
        r = sda;
        hold(3);
        scl = 1'b0;
        hold(3);
    endtask
    task automatic start_c;
        sda_rel = 1'b1;
        hold(3);
        scl = 1'b1;
        hold(5);
        sda_rel = 1'b0;
        hold(5);
        scl = 1'b0;
    endtask
    task automatic stop_c;
        sda_rel = 1'b0;
        hold(3);
        scl = 1'b1;
        hold(5);
        sda_rel = 1'b1;
        hold(5);
    endtask
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, v[i]);
        bit_x(last, r);
    endtask
    task automatic write_word(input logic [7:0] c, input logic [15:0] w,
                              output logic ok);
        logic a;
        start_c;
        byte_out({`GSC_DEV_ADDR, 1'b0}, ok);
        byte_out(c, a);
        byte_out(w[7:0], a);
        byte_out(w[15:8], a);
        stop_c;
    endtask
    // code, then repeated start and read
    task automatic read_word(input logic [7:0] c, output logic [15:0] w);
        logic a;
        start_c;
        byte_out({`GSC_DEV_ADDR, 1'b0}, a);
        byte_out(c, a);
        start_c;
        byte_out({`GSC_DEV_ADDR, 1'b1}, a);
        byte_in(1'b0, w[7:0]);
        byte_in(1'b1, w[15:8]);
        stop_c;
    endtask
endmodule

// >>> testbench/gsc_command_map_assertions.sv
// Port-level assertions for the gauge command map
`timescale 1ns/10ps
module gsc_map_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Bus pins
    input wire logic       scl_in,
    input wire logic       sda_oe,
    // Mode inputs and state
    input wire logic       init_done,
    input wire logic       sleep_cond,
    input wire logic       wake_evt,
    input wire logic [2:0] power_mode,
    input wire logic       locked_state,
    // Control and extended outputs
    input wire logic       reset_req,
    input wire logic       restore_req,
    input wire logic       ext_wr_stb,
    input wire logic [7:0] ext_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_to_normal;
        ##[1:3] power_mode == 3'h1;
    endsequence
    sequence s_to_sleep;
        ##[1:3] power_mode == 3'h2;
    endsequence
    a_reset_state: assert property (
        $fell(sys_rst) |-> power_mode == 3'h0 && !locked_state && !sda_oe)
        else $error("Reset values wrong");
    a_init_quiet: assert property (
        power_mode == 3'h0 |-> !sda_oe)
        else $error("Bus driven while initializing");
    a_init_leave: assert property (
        power_mode == 3'h0 && init_done |-> s_to_normal)
        else $error("Initialization not left");
    a_sleep_enter: assert property (
        power_mode == 3'h1 && sleep_cond |-> s_to_sleep)
        else $error("Sleep not entered");
    a_sleep_exit: assert property (
        power_mode == 3'h2 && !sleep_cond |-> s_to_normal)
        else $error("Sleep not left");
    a_hib_wake: assert property (
        power_mode == 3'h4 && wake_evt |-> s_to_normal)
        else $error("Hibernate not left on wake");
    a_mode_range: assert property (
        power_mode <= 3'h4)
        else $error("Power mode out of range");
    a_lock_sticky: assert property (
        locked_state |=> locked_state)
        else $error("Locked state dropped");
    a_locked_no_req: assert property (
        $past(locked_state) |-> !reset_req && !restore_req)
        else $error("Request issued while locked");
    a_sda_scl_low: assert property (
        !$stable(sda_oe) |-> !scl_in)
        else $error("Data line moved with clock high");
    a_ext_code: assert property (
        ext_wr_stb |-> ext_code > 8'h21)
        else $error("Extended write at standard code");
endmodule
bind gsc_command_map gsc_map_checker chk_u (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_oe(sda_oe),
    .init_done(init_done), .sleep_cond(sleep_cond), .wake_evt(wake_evt),
    .power_mode(power_mode), .locked_state(locked_state),
    .reset_req(reset_req), .restore_req(restore_req),
    .ext_wr_stb(ext_wr_stb), .ext_code(ext_code)
);

// >>> testbench/gsc_command_map_test.sv
// Self-checking bench for the gauge command map
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    error_cnt++; $display("Error at %0t: got %h expected %h", \
    $time, got, exp); end end
module gsc_command_map_test;
    logic        clk, sys_rst, scl, sda_rel, sda_line, sda_oe, upd_stb;
    logic        init_done, sleep_cond, wake_evt, locked_state, ok;
    logic [2:0]  power_mode;
    logic [7:0]  upd_code;
    logic [15:0] upd_data, w, obs_val, exp_v;
    logic [15:0] mem [17];
    logic [15:0] exp_q [$];
    logic [15:0] subs [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003};
    logic [15:0] vals [4] = '{16'h2080, 16'h1234, 16'h0100, 16'h00A0};
    logic        reset_req, restore_req, ext_wr_stb;
    logic [7:0]  ext_code, ext_data;
    logic [15:0] ext_seen;
    int          error_cnt, n_compared, seed, i, req_cnt;
    event        obs_ev;
    // Open drain with pull-up
    assign sda_line = sda_rel & ~sda_oe;
    gsc_command_map dut_u (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(), .sda_oe(sda_oe), .upd_stb(upd_stb),
        .upd_code(upd_code), .upd_data(upd_data), .init_done(init_done),
        .sleep_cond(sleep_cond), .wake_evt(wake_evt),
        .power_mode(power_mode), .locked_state(locked_state),
        .reset_req(reset_req), .restore_req(restore_req),
        .ext_wr_stb(ext_wr_stb), .ext_code(ext_code), .ext_data(ext_data),
        .ext_rd_data(8'h5A));
    gsc_host_model host_u (.clk(clk), .scl(scl), .sda_rel(sda_rel),
        .sda(sda_line));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(obs_ev) begin
        exp_v = exp_q.pop_front();
        `CHK(obs_val, exp_v)
    end
    // Pulses are too short for the host tasks, so they are latched
    always @(posedge clk) begin
        req_cnt <= req_cnt + 2 * reset_req + restore_req;
        if (ext_wr_stb)
            ext_seen <= {ext_code, ext_data};
    end
    task automatic check(input logic [15:0] got, input logic [15:0] e);
        exp_q.push_back(e);
        obs_val = got;
        -> obs_ev;
        @(negedge clk);
    endtask
    task automatic upd(input logic [7:0] c, input logic [15:0] d);
        upd_code = c;
        upd_data = d;
        upd_stb = 1'b1;
        @(negedge clk);
        upd_stb = 1'b0;
        @(negedge clk);
    endtask
    task automatic check_all();
        for (int k = 1; k < 17; k++) begin
            host_u.read_word(8'(2 * k), w);
            check(w, mem[k]);
        end
    endtask
    task automatic end_of_test();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (power_mode !== m && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (power_mode !== m) begin
            error_cnt++;
            end_of_test();
        end
        check({13'h0, power_mode}, {13'h0, m});
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        seed = 32'h0ADFAC9E;
        {sys_rst, upd_stb, init_done, sleep_cond, wake_evt} = 5'h10;
        upd_code = 8'h00;
        upd_data = 16'h0000;
        for (i = 0; i < 17; i++)
            mem[i] = 16'h0000;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        host_u.write_word(8'h1A, 16'h0000, ok);
        check({15'h0, ok}, 16'h0000);
        init_done = 1'b1;
        wait_mode(3'h1);
        for (i = 1; i < 17; i++)
            if (i != 13) begin
                mem[i] = 16'($random(seed));
                upd(8'(2 * i), mem[i]);
            end
        check_all();
        // Open state: any mapped word takes host writes
        mem[2] = 16'($random(seed));
        host_u.write_word(8'h04, mem[2], ok);
        host_u.write_word(8'h1A, 16'hFFFF, ok);
        host_u.write_word(8'h30, 16'hC3C3, ok);
        check(ext_seen, 16'h31C3);
        host_u.write_word(8'h00, 16'h0041, ok);
        host_u.write_word(8'h00, 16'h0015, ok);
        check(16'(req_cnt), 16'h0003);
        host_u.write_word(8'h00, 16'h0020, ok);
        check({15'h0, locked_state}, 16'h0001);
        host_u.write_word(8'h00, 16'h0041, ok);
        host_u.write_word(8'h00, 16'h0015, ok);
        check(16'(req_cnt), 16'h0003);
        mem[1] = 16'($random(seed));
        host_u.write_word(8'h02, mem[1], ok);
        for (i = 2; i < 4; i++)
            host_u.write_word(8'(2 * i), 16'h5AA5, ok);
        check_all();
        host_u.read_word(8'h30, w);
        check(w, 16'h5A5A);
        for (i = 0; i < 4; i++) begin
            host_u.write_word(8'h00, subs[i], ok);
            host_u.read_word(8'h00, w);
            check(w, vals[i]);
        end
        host_u.write_word(8'h00, 16'h0011, ok);
        sleep_cond = 1'b1;
        wait_mode(3'h4);
        host_u.write_word(8'h1A, 16'h0000, ok);
        check({15'h0, ok}, 16'h0000);
        sleep_cond = 1'b0;
        wake_evt = 1'b1;
        wait_mode(3'h1);
        wake_evt = 1'b0;
        host_u.write_word(8'h00, 16'h0010, ok);
        sleep_cond = 1'b1;
        wait_mode(3'h3);
        // Traffic wakes deep idle; the hibernate flag clears on request
        host_u.write_word(8'h00, 16'h0012, ok);
        host_u.read_word(8'h00, w);
        check(w, 16'h2090);
        wait_mode(3'h2);
        sleep_cond = 1'b0;
        wait_mode(3'h1);
        end_of_test();
    end
endmodule
